// ==== htc_consts.svh ====
// Offsets, field positions and reset values of the hard timer/counter
`ifndef HTC_CONSTS_SVH
`define HTC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define HTC_A_CTRL   8'h00
`define HTC_A_TOP    8'h04
`define HTC_A_CMP    8'h08
`define HTC_A_CNT    8'h0C
`define HTC_A_CAP    8'h10
`define HTC_A_STAT   8'h14
`define HTC_A_MASK   8'h18
`define HTC_AW       8

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define HTC_F_EN     0
`define HTC_F_MODE   2:1
`define HTC_F_SRC    3
`define HTC_F_CAPEN  4
`define HTC_F_PSC    15:8
`define HTC_CTRL_W   16
`define HTC_PSC_W    8

// ----------------------------------------------------------------
// Event bits, shared by status and mask
// ----------------------------------------------------------------
`define HTC_I_OVF    0
`define HTC_I_CMP    1
`define HTC_I_CAP    2
`define HTC_IRQ_W    3

// ----------------------------------------------------------------
// Pin synchroniser bits and reset values
// ----------------------------------------------------------------
`define HTC_S_CLK    0
`define HTC_S_RST    1
`define HTC_S_CAP    2
`define HTC_S_RSTV   3'h2
`define HTC_CTRL_RST 16'h0000
`define HTC_TOP_RST  16'hFFFF
`define HTC_CMP_RST  16'h0000
`define HTC_DATA_Z   32'h0000_0000

`endif

// ==== htc_pkg.sv ====
// Types shared by the hard timer/counter
package htc_pkg;
  // Operating modes, in control-field order
  typedef enum logic [1:0] {
    HTC_WDT,
    HTC_CTC,
    HTC_FPWM,
    HTC_PFC
  } htc_mode_t;
endpackage

// ==== htc_timer.sv ====
// Hard 16-bit timer/counter with compare, PWM, capture, IRQ and APB registers
// Contract
// - 16-bit up/down counter with its own compare unit producing PWM.
// - Four modes: watchdog, clear on compare match, fast PWM, phase/frequency PWM.
// - Counting clock source is selectable and divided by a programmable prescaler.
// - Overflow, compare match and capture each set their own flag.
// - One level interrupt output plus a separate wake-up interrupt.
// - Non-PWM, bus mode, capture on: synced rising edge copies count.
// - Stand-alone: interrupt is overflow flag; bus mode: status and mask govern.
// - Reset pin enable is fixed at build so the reset pin always works.
// - Stand-alone option: preset controls, bus reads only (writes refused), no capture; reset pin, and clock pin if the preset selects it.
// - Control and status registers are read and written through the bus.
// - PWM output glitch-free even when period changes while running.
// - Compare-driven waveform drives the output pin in waveform modes.
`timescale 1ns/1ps
`include "htc_consts.svh"

module htc_timer
  import htc_pkg::*;
#(
  parameter int             CW       = 16,
  parameter logic           RST_PEN  = 1'b1,
  parameter logic [15:0]    PRE_CTRL = `HTC_CTRL_RST,
  parameter logic [CW-1:0]  PRE_TOP  = `HTC_TOP_RST,
  parameter logic [CW-1:0]  PRE_CMP  = `HTC_CMP_RST
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [`HTC_AW-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               standalone_cfg,
  input  wire logic               timer_clock_in,
  input  wire logic               timer_reset_n,
  input  wire logic               capture_trigger_in,
  output logic                    timer_irq_out,
  output logic                    wake_irq_out,
  output logic                    timer_wave_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] s1_r, s2_r, s3_r, f_r, f_nxt, rise;

  // A change counts once second and third stages agree
  always_comb begin
    f_nxt = (s2_r & s3_r) | (f_r & (s2_r | s3_r));
    rise  = f_nxt & ~f_r;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s1_r <= `HTC_S_RSTV;
      s2_r <= `HTC_S_RSTV;
      s3_r <= `HTC_S_RSTV;
      f_r  <= `HTC_S_RSTV;
    end else begin
      s1_r <= {capture_trigger_in, timer_reset_n, timer_clock_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r  <= f_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register file state
  // ----------------------------------------------------------------
  logic [15:0]            ctrl_r, ctrl_nxt, ctrl_e;
  logic [CW-1:0]          top_r, top_nxt, cmp_r, cmp_nxt;
  logic [CW-1:0]          top_e, cmp_e, cap_r, cap_nxt;
  logic [`HTC_IRQ_W-1:0]  stat_r, stat_nxt, mask_r, mask_nxt, ev, w1c;
  logic [31:0]            prdata_r, prdata_nxt;
  logic                   pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic                   irq_r, irq_nxt, wake_r, wake_nxt;
  logic                   commit, wr, hit, ro;
  logic                   tmr_rst;
  logic [CW-1:0]          cnt_r;

  // Stand-alone runs from preset controls, bus values ignored
  always_comb begin
    ctrl_e = standalone_cfg ? PRE_CTRL : ctrl_r;
    top_e  = standalone_cfg ? PRE_TOP  : top_r;
    cmp_e  = standalone_cfg ? PRE_CMP  : cmp_r;
  end

  // Reset pin enable is a build constant, never writable
  assign tmr_rst = RST_PEN & ~f_r[`HTC_S_RST];

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ----------------------------------------------------------------
  always_comb begin
    commit      = psel & penable & pready_r;
    wr          = commit & pwrite & ~pslverr_r;
    pready_nxt  = psel & penable & ~pready_r;
    hit         = 1'b1;
    ro          = 1'b0;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    ctrl_nxt    = ctrl_r;
    top_nxt     = top_r;
    cmp_nxt     = cmp_r;
    mask_nxt    = mask_r;
    w1c         = '0;
    // Read data sampled once, then held while pready stands
    if (pready_nxt) begin
      prdata_nxt = `HTC_DATA_Z;
      unique case (paddr)
        `HTC_A_CTRL: prdata_nxt[`HTC_CTRL_W-1:0] = ctrl_e;
        `HTC_A_TOP:  prdata_nxt[CW-1:0] = top_e;
        `HTC_A_CMP:  prdata_nxt[CW-1:0] = cmp_e;
        `HTC_A_CNT: begin
          prdata_nxt[CW-1:0] = cnt_r;
          ro = 1'b1;
        end
        `HTC_A_CAP: begin
          prdata_nxt[CW-1:0] = cap_r;
          ro = 1'b1;
        end
        `HTC_A_STAT: prdata_nxt[`HTC_IRQ_W-1:0] = stat_r;
        `HTC_A_MASK: prdata_nxt[`HTC_IRQ_W-1:0] = mask_r;
        default:     hit = 1'b0;
      endcase
      // Writes refused when unmapped, read-only or stand-alone
      pslverr_nxt = ~hit | (pwrite & (ro | standalone_cfg));
    end
    // Write takes effect only at the edge that completes the access
    if (wr) begin
      unique case (paddr)
        `HTC_A_CTRL: ctrl_nxt = pwdata[`HTC_CTRL_W-1:0];
        `HTC_A_TOP:  top_nxt  = pwdata[CW-1:0];
        `HTC_A_CMP:  cmp_nxt  = pwdata[CW-1:0];
        `HTC_A_STAT: w1c      = pwdata[`HTC_IRQ_W-1:0];
        `HTC_A_MASK: mask_nxt = pwdata[`HTC_IRQ_W-1:0];
        default:     w1c      = '0;
      endcase
    end
    // Set wins over a clear in the same cycle
    stat_nxt = tmr_rst ? '0 : ((stat_r & ~w1c) | ev);
    // Stand-alone exposes the overflow flag directly
    irq_nxt  = standalone_cfg ? stat_r[`HTC_I_OVF] : |(stat_r & mask_r);
    wake_nxt = standalone_cfg ? ev[`HTC_I_OVF] : |(ev & mask_r);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_r    <= `HTC_CTRL_RST;
      top_r     <= `HTC_TOP_RST;
      cmp_r     <= `HTC_CMP_RST;
      mask_r    <= '0;
      stat_r    <= '0;
      prdata_r  <= `HTC_DATA_Z;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r     <= 1'b0;
      wake_r    <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      top_r     <= top_nxt;
      cmp_r     <= cmp_nxt;
      mask_r    <= mask_nxt;
      stat_r    <= stat_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r     <= irq_nxt;
      wake_r    <= wake_nxt;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign timer_irq_out  = irq_r;
  assign wake_irq_out   = wake_r;

  // ----------------------------------------------------------------
  // Prescaler and counter core
  // ----------------------------------------------------------------
  logic [`HTC_PSC_W-1:0] psc_r, psc_nxt;
  logic [CW-1:0]         cnt_nxt, top_a_r, top_a_nxt, cmp_a_r, cmp_a_nxt;
  logic                  dn_r, dn_nxt, wave_r, wave_nxt;
  logic                  en, src_tick, tick, is_pwm, bound;
  htc_mode_t             mode;

  always_comb begin
    en       = ctrl_e[`HTC_F_EN];
    mode     = htc_mode_t'(ctrl_e[`HTC_F_MODE]);
    is_pwm   = (mode == HTC_FPWM) || (mode == HTC_PFC);
    // Source: every system clock, or synced rising edge of the pin
    src_tick = ctrl_e[`HTC_F_SRC] ? rise[`HTC_S_CLK] : 1'b1;
    // At or above the setting, so lowering the divider mid-count cannot stall it
    tick     = en & src_tick & (psc_r >= ctrl_e[`HTC_F_PSC]);
    psc_nxt  = psc_r;
    if (!en || tmr_rst || tick) begin
      psc_nxt = '0;
    end else if (src_tick) begin
      psc_nxt = psc_r + 1'b1;
    end
    cnt_nxt   = cnt_r;
    dn_nxt    = dn_r;
    bound     = 1'b0;
    ev        = '0;
    cap_nxt   = cap_r;
    if (tick) begin
      unique case (mode)
        HTC_WDT: begin
          cnt_nxt = (cnt_r == top_a_r) ? '0 : cnt_r + 1'b1;
          ev[`HTC_I_OVF] = (cnt_r == top_a_r);
        end
        HTC_CTC: begin
          cnt_nxt = (cnt_r == cmp_a_r) ? '0 : cnt_r + 1'b1;
          ev[`HTC_I_CMP] = (cnt_r == cmp_a_r);
          ev[`HTC_I_OVF] = (cnt_r == '1);
        end
        HTC_FPWM: begin
          bound   = (cnt_r >= top_a_r);
          cnt_nxt = bound ? '0 : cnt_r + 1'b1;
          ev[`HTC_I_OVF] = bound;
          ev[`HTC_I_CMP] = (cnt_r == cmp_a_r);
        end
        HTC_PFC: begin
          // Turn at top, overflow and reload at bottom
          if (!dn_r) begin
            dn_nxt  = (cnt_r >= top_a_r);
            cnt_nxt = dn_nxt ? cnt_r - 1'b1 : cnt_r + 1'b1;
            if (cnt_r == '0 && dn_nxt) begin
              cnt_nxt = '0;
            end
          end else if (cnt_r == '0) begin
            dn_nxt  = 1'b0;
            bound   = 1'b1;
            cnt_nxt = (top_a_r == '0) ? '0 : cnt_r + 1'b1;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
          ev[`HTC_I_OVF] = bound;
          ev[`HTC_I_CMP] = (cnt_r == cmp_a_r);
        end
      endcase
    end
    if (!is_pwm) begin
      dn_nxt = 1'b0;
    end
    // Time stamp only outside PWM, with the bus in use
    if (rise[`HTC_S_CAP] && !is_pwm && !standalone_cfg && ctrl_e[`HTC_F_CAPEN]) begin
      cap_nxt = cnt_r;
      ev[`HTC_I_CAP] = 1'b1;
    end
    if (tmr_rst) begin
      cnt_nxt = '0;
      dn_nxt  = 1'b0;
      ev      = '0;
    end
    // While a PWM mode runs, shadows reload only at period boundary so no runt pulse appears
    top_a_nxt = top_a_r;
    cmp_a_nxt = cmp_a_r;
    if (!is_pwm || !en || bound || tmr_rst) begin
      top_a_nxt = top_e;
      cmp_a_nxt = cmp_e;
    end
    // Registered compare output: toggle on match, level in PWM
    wave_nxt = 1'b0;
    if (is_pwm) begin
      wave_nxt = (cnt_nxt < cmp_a_nxt);
    end else if (mode == HTC_CTC) begin
      wave_nxt = wave_r ^ ev[`HTC_I_CMP];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      psc_r   <= '0;
      cnt_r   <= '0;
      dn_r    <= 1'b0;
      cap_r   <= '0;
      top_a_r <= `HTC_TOP_RST;
      cmp_a_r <= `HTC_CMP_RST;
      wave_r  <= 1'b0;
    end else begin
      psc_r   <= psc_nxt;
      cnt_r   <= cnt_nxt;
      dn_r    <= dn_nxt;
      cap_r   <= cap_nxt;
      top_a_r <= top_a_nxt;
      cmp_a_r <= cmp_a_nxt;
      wave_r  <= wave_nxt;
    end
  end

  assign timer_wave_out = wave_r;

  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_apb_ans;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("APB answer not one cycle");

  property p_cnt_top;
    mode == HTC_FPWM && $past(mode == HTC_FPWM) && $past(en) |-> cnt_r <= top_a_r;
  endproperty
  a_cnt_top: assert property (p_cnt_top) else $error("Fast PWM count above top");

  property p_ctc_clr;
    tick && mode == HTC_CTC && cnt_r == cmp_a_r && !tmr_rst |=> cnt_r == '0;
  endproperty
  a_ctc_clr: assert property (p_ctc_clr) else $error("No clear on match");

  property p_psc;
    tick && !tmr_rst |=> psc_r == '0;
  endproperty
  a_psc: assert property (p_psc) else $error("Prescaler not restarted");

  property p_ovf_flag;
    ev[`HTC_I_OVF] |=> stat_r[`HTC_I_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("Overflow flag lost");

  property p_irq;
    !standalone_cfg && ((stat_r & mask_r) != '0) |=> timer_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt level wrong");

  property p_cap;
    ev[`HTC_I_CAP] |=> cap_r == $past(cnt_r);
  endproperty
  a_cap: assert property (p_cap) else $error("Capture value wrong");

  property p_cap_sync;
    $rose(capture_trigger_in) |-> !ev[`HTC_I_CAP] [*2];
  endproperty
  a_cap_sync: assert property (p_cap_sync) else $error("Capture not synchronised");

  property p_wave;
    $past(is_pwm) && is_pwm |-> timer_wave_out == (cnt_r < cmp_a_r);
  endproperty
  a_wave: assert property (p_wave) else $error("PWM level mismatch");

  property p_rst_pin;
    tmr_rst |=> cnt_r == '0 && stat_r == '0;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("Reset pin ignored");

  c_pfc_turn: cover property (mode == HTC_PFC && !dn_r ##1 dn_r);
  c_cap:      cover property (ev[`HTC_I_CAP]);
  c_irq:      cover property (!timer_irq_out ##1 timer_irq_out);

endmodule

// ==== htc_apb_master.sv ====
// APB master model driving the timer register port
`timescale 1ns/1ps

module htc_apb_master (
  input  wire logic        sys_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // --------------------------------------------------
  // One transfer; request held until pready sampled
  // --------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No fixed latency assumed; bench timeout ends a hang
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ==== htc_timer_tb_top.sv ====
// Self-checking bench for the hard timer/counter
`timescale 1ns/1ps
`include "htc_consts.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end

module htc_timer_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, c1;
  logic        err, irq, wake, wave;
  logic        standalone_cfg = 1'b0;
  logic        timer_clock_in = 1'b0;
  logic        timer_reset_n = 1'b1;
  logic        capture_trigger_in = 1'b0;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          wakes = 0;
  int          hi;

  always #2.5 sys_clk = ~sys_clk;

  htc_apb_master MST (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  htc_timer DUT (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standalone_cfg(standalone_cfg), .timer_clock_in(timer_clock_in),
    .timer_reset_n(timer_reset_n), .capture_trigger_in(capture_trigger_in),
    .timer_irq_out(irq), .wake_irq_out(wake), .timer_wave_out(wave));

  // --------------------------------------------------
  // Hang guard and wake pulse tally
  // --------------------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (wake === 1'b1) wakes++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    MST.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rdx(input logic [7:0] a);
    MST.xfer(1'b0, a, 32'h0000_0000, rd, err);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Pin pulse, long enough for the three-flop synchroniser
  task automatic cap_pulse();
    @(posedge sys_clk) capture_trigger_in <= 1'b1;
    cycles(8);
    @(posedge sys_clk) capture_trigger_in <= 1'b0;
    cycles(10);
  endtask

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    cycles(12);
    @(posedge sys_clk) rst_b <= 1'b1;
    // Reset values
    rdx(`HTC_A_CTRL); `CHK("ctrl", 32'h0000_0000, rd)
    rdx(`HTC_A_TOP);  `CHK("top", 32'h0000_FFFF, rd)
    rdx(`HTC_A_MASK); `CHK("mask", 32'h0000_0000, rd)
    // Read-only and unmapped places refuse
    wr(`HTC_A_CNT, 32'h0000_1234); `CHK("cnt wr err", 1'b1, err)
    rdx(8'h1C); `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    wr(`HTC_A_CMP, 32'h0000_0003); `CHK("cmp wr err", 1'b0, err)
    rdx(`HTC_A_CMP); `CHK("cmp", 32'h0000_0003, rd)
    // Fast PWM duty over whole periods, period changed while running
    for (int t = 9; t <= 19; t += 10) begin
      wr(`HTC_A_TOP, t);
      wr(`HTC_A_CTRL, 32'h0000_0015);
      cycles(60);
      hi = 0;
      repeat (4 * (t + 1)) @(posedge sys_clk) hi += (wave === 1'b1);
      `CHK("pwm high cycles", 12, hi)
    end
    // Capture ignored in PWM
    wr(`HTC_A_STAT, 32'h0000_0007);
    cap_pulse();
    rdx(`HTC_A_STAT); `CHK("pwm cap flag", 1'b0, rd[`HTC_I_CAP])
    // Overflow flag drives irq only when unmasked
    `CHK("ovf flag", 1'b1, rd[`HTC_I_OVF])
    `CHK("irq masked", 1'b0, irq)
    wr(`HTC_A_MASK, 32'h0000_0001);
    // Longer than one overflow period, so a wake pulse must fall inside
    cycles(24);
    `CHK("irq on", 1'b1, irq)
    wr(`HTC_A_MASK, 32'h0000_0000);
    cycles(3);
    `CHK("irq off", 1'b0, irq)
    `CHK("wake seen", 1'b1, wakes > 0)
    // Capture in clear-on-match mode
    wr(`HTC_A_CMP, 32'h0000_0100);
    wr(`HTC_A_CTRL, 32'h0000_0013);
    wr(`HTC_A_STAT, 32'h0000_0007);
    rdx(`HTC_A_CNT); c1 = rd;
    cap_pulse();
    rdx(`HTC_A_STAT); `CHK("ctc cap flag", 1'b1, rd[`HTC_I_CAP])
    // Stamp lags the count read by the synchroniser delay, never less
    rdx(`HTC_A_CAP); `CHK("cap delay", 1'b1, (rd - c1) inside {[4:8]})
    // Prescaler divide by four in watchdog mode
    wr(`HTC_A_TOP, 32'h0000_FFFF);
    wr(`HTC_A_CTRL, 32'h0000_0301);
    rdx(`HTC_A_CNT); c1 = rd;
    cycles(80);
    rdx(`HTC_A_CNT); `CHK("prescaled", 1'b1, (rd - c1) inside {[19:22]})
    // Pin as count source
    wr(`HTC_A_CTRL, 32'h0000_0009);
    cycles(8);
    rdx(`HTC_A_CNT); c1 = rd;
    repeat (5) begin
      @(posedge sys_clk) timer_clock_in <= 1'b1;
      cycles(6);
      @(posedge sys_clk) timer_clock_in <= 1'b0;
      cycles(6);
    end
    cycles(8);
    rdx(`HTC_A_CNT); `CHK("pin counts", 32'd5, rd - c1)
    // Phase and frequency correct PWM: 0 up to 9 and back, five high cycles a period
    wr(`HTC_A_TOP, 32'h0000_0009);
    wr(`HTC_A_CMP, 32'h0000_0003);
    wr(`HTC_A_CTRL, 32'h0000_0007);
    // Old count lies above top, so let it run down first
    cycles(200);
    hi = 0;
    repeat (72) @(posedge sys_clk) hi += (wave === 1'b1);
    `CHK("pfc high cycles", 20, hi)
    // Reset pin clears count and status
    @(posedge sys_clk) timer_reset_n <= 1'b0;
    cycles(8);
    rdx(`HTC_A_CNT); `CHK("cnt reset pin", 32'h0000_0000, rd)
    rdx(`HTC_A_STAT); `CHK("stat reset pin", 32'h0000_0000, rd)
    @(posedge sys_clk) timer_reset_n <= 1'b1;
    // Stand-alone refuses bus writes
    @(posedge sys_clk) standalone_cfg <= 1'b1;
    wr(`HTC_A_TOP, 32'h0000_0055); `CHK("standalone err", 1'b1, err)
    complete_run();
  end
endmodule
